// ---- dxc_bank.sv ----
/*
  dxc_bank: shadow of one memory bank's state as the controller sees it.
  Assumes tick marks one memory clock cycle and issue is only raised with a legal command.
*/
`timescale 1ns/1ps
module dxc_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // command issued to this bank
  input wire logic tick,
  input wire logic issue,
  input dxc_pkg::dxc_cmd_type cmd,
  input wire logic ap,
  // shadow state
  output dxc_pkg::dxc_bank_state_type state,
  output logic [dxc_pkg::CW-1:0] count
);
  import dxc_pkg::*;

  dxc_bank_state_type state_q;
  logic [CW-1:0] cnt_q;

  assign state = state_q;
  assign count = cnt_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= DXC_IDLE;
      cnt_q <= CNT_ZERO;
    end else if (tick && issue) begin
      unique case (cmd)
        DXC_ACT: begin
          state_q <= DXC_ACTIVATING;
          cnt_q <= dxc_cyc(RCD_CYC);
        end
        DXC_RD: begin
          // read precharge starts where the earliest full-burst precharge would
          state_q <= ap ? DXC_RD_AP : DXC_READING;
          cnt_q <= dxc_cyc(RD_ACCESS_CYC);
        end
        DXC_WR: begin
          state_q <= ap ? DXC_WR_AP : DXC_WRITING;
          cnt_q <= dxc_cyc(WR_ACCESS_CYC);
        end
        DXC_PRE: begin
          // an idle bank stays idle; a repeated precharge restarts the period
          if (state_q != DXC_IDLE) begin
            state_q <= DXC_PRECHARGING;
            cnt_q <= dxc_cyc(RP_CYC);
          end
        end
        default: begin
        end
      endcase
    end else if (tick) begin
      if (cnt_q != CNT_ZERO) begin
        cnt_q <= dxc_dec(cnt_q);
      end else begin
        unique case (state_q)
          DXC_ACTIVATING, DXC_READING, DXC_WRITING: state_q <= DXC_ACTIVE;
          DXC_RD_AP, DXC_WR_AP: begin
            state_q <= DXC_PRECHARGING;
            cnt_q <= dxc_cyc(RP_CYC);
          end
          DXC_PRECHARGING: state_q <= DXC_IDLE;
          DXC_IDLE, DXC_ACTIVE: state_q <= state_q;
        endcase
      end
    end
  end

endmodule // dxc_bank

// ---- dxc_ctrl.sv ----
/*
  dxc_ctrl: ddr2 command controller top. Takes one request at a time, holds it
  until the memory's cross-bank rules allow it, then drives it on the command pins.
  Assumes the memory samples pins on the rising edge of ck and that the requester
  holds its request stable until done or error pulses.
*/
`timescale 1ns/1ps

// Contract
// - pins change on falling ck, so cs,ras,cas,we,cke are stable at rising edges.
// - commands go out only when cke was high last cycle and is high now.
// - with every other bank idle, bank m takes whatever its own state allows.
// - activate and precharge go to bank m whatever other banks do; read and write also wait out data-bus gaps.
// - every command is checked against bank state; impossible activate, read and write are refused.
// - auto-precharge banks never block other banks beyond data-bus gaps.
// - read and write gaps keep data bus free of contention.
// - after write, read waits CL-1+BL/2+tWTR, write BL/2, others 1.
// - after read, read waits BL/2, write BL/2+2, others 1.
// - write-to-read turnaround uses the larger of two and tWTR in cycles.
// - a write after a read waits until its data cannot overlap the read burst.
// - refresh and load mode only when all banks are idle.
// - load mode writes bank-address register; nothing executes until tMRD passes.
// - activate opens the row; a different row needs precharge first.
// - bursts of four are never cut short by another command.
module dxc_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  input dxc_pkg::dxc_req_type req,
  output logic req_done,
  output logic req_err,
  // memory pins
  output logic ck,
  output logic ck_n,
  output dxc_pkg::dxc_pins_type pins
);
  import dxc_pkg::*;

  logic ck_q;
  logic ck_n_q;
  logic tick;
  logic cke_q;
  logic cke_prev_q;
  logic done_q;
  logic err_q;
  dxc_pins_type pins_q;
  dxc_pins_type pins_d;
  logic [CW-1:0] rd_gap_q;
  logic [CW-1:0] wr_gap_q;
  logic [CW-1:0] quiet_q;
  dxc_bank_state_type bank_st [NBANK];
  logic [CW-1:0] bank_cnt [NBANK];
  logic [NBANK-1:0] bank_issue;
  dxc_bank_state_type tgt_st;
  logic [CW-1:0] tgt_cnt;
  logic all_idle;
  logic link_up;
  logic col_open;
  logic legal;
  logic never;
  logic issue;

  assign ck = ck_q;
  assign ck_n = ck_n_q;
  assign pins = pins_q;
  assign req_done = done_q;
  assign req_err = err_q;

  // tick is the mclk edge on which ck falls; pins change there and are
  // sampled half a memory cycle later, which keeps setup and hold balanced
  assign tick = ck_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ck_q <= 1'b0;
      ck_n_q <= 1'b1;
    end else begin
      ck_q <= ~ck_q;
      ck_n_q <= ck_q;
    end
  end

  // cke is raised once after reset; power-up sequencing is left to the requester
  always_ff @(posedge mclk) begin
    if (rst) begin
      cke_q <= 1'b0;
      cke_prev_q <= 1'b0;
    end else if (tick) begin
      cke_q <= 1'b1;
      cke_prev_q <= cke_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NBANK; gi++) begin : g_bank
      assign bank_issue[gi] = issue && (req.bank == BAW'(gi));
      dxc_bank u_bank (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .issue(bank_issue[gi]),
        .cmd(req.cmd),
        .ap(req.ap),
        .state(bank_st[gi]),
        .count(bank_cnt[gi])
      );
    end
  endgenerate

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < NBANK; i++) begin
      if (bank_st[i] != DXC_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  assign tgt_st = bank_st[req.bank];
  assign tgt_cnt = bank_cnt[req.bank];
  assign link_up = cke_q && cke_prev_q;

  // column commands may be posted early by the additive latency
  assign col_open = (tgt_st == DXC_ACTIVE) || (tgt_st == DXC_READING) || (tgt_st == DXC_WRITING) ||
    ((tgt_st == DXC_ACTIVATING) && (tgt_cnt <= CW'(AL)));

  // legality against the target bank, the data-bus gaps and global quiet time
  always_comb begin
    legal = 1'b0;
    never = 1'b0;
    unique case (req.cmd)
      DXC_ACT: begin
        legal = (tgt_st == DXC_IDLE);
        never = (tgt_st == DXC_ACTIVATING) || (tgt_st == DXC_ACTIVE) ||
          (tgt_st == DXC_READING) || (tgt_st == DXC_WRITING);
      end
      DXC_RD: begin
        legal = col_open && (rd_gap_q == CNT_ZERO);
        never = (tgt_st == DXC_IDLE) || (tgt_st == DXC_PRECHARGING) ||
          (tgt_st == DXC_RD_AP) || (tgt_st == DXC_WR_AP);
      end
      DXC_WR: begin
        legal = col_open && (wr_gap_q == CNT_ZERO);
        never = (tgt_st == DXC_IDLE) || (tgt_st == DXC_PRECHARGING) ||
          (tgt_st == DXC_RD_AP) || (tgt_st == DXC_WR_AP);
      end
      DXC_PRE: begin
        // precharge waits out any burst in the same bank
        legal = (tgt_st == DXC_IDLE) || (tgt_st == DXC_ACTIVE) ||
          (tgt_st == DXC_PRECHARGING);
      end
      DXC_REF, DXC_LM: begin
        legal = all_idle;
      end
      default: begin
        // unused command codes are refused outright
        never = 1'b1;
      end
    endcase
  end

  assign issue = tick && req_valid && link_up && (quiet_q == CNT_ZERO) && legal && !done_q;

  // gaps between column commands; a gap of one cycle is met by one command per cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_gap_q <= CNT_ZERO;
      wr_gap_q <= CNT_ZERO;
    end else if (tick) begin
      if (issue && (req.cmd == DXC_RD)) begin
        rd_gap_q <= dxc_max(dxc_dec(rd_gap_q), dxc_cyc(GAP_RD_RD));
        wr_gap_q <= dxc_max(dxc_dec(wr_gap_q), dxc_cyc(GAP_RD_WR));
      end else if (issue && (req.cmd == DXC_WR)) begin
        rd_gap_q <= dxc_max(dxc_dec(rd_gap_q), dxc_cyc(GAP_WR_RD));
        wr_gap_q <= dxc_max(dxc_dec(wr_gap_q), dxc_cyc(GAP_WR_WR));
      end else begin
        rd_gap_q <= dxc_dec(rd_gap_q);
        wr_gap_q <= dxc_dec(wr_gap_q);
      end
    end
  end

  // quiet time after load mode or refresh blocks every executable command
  always_ff @(posedge mclk) begin
    if (rst) begin
      quiet_q <= CNT_ZERO;
    end else if (tick) begin
      if (issue && (req.cmd == DXC_LM)) begin
        quiet_q <= dxc_cyc(T_MRD_CK);
      end else if (issue && (req.cmd == DXC_REF)) begin
        quiet_q <= dxc_cyc(RFC_CYC);
      end else begin
        quiet_q <= dxc_dec(quiet_q);
      end
    end
  end

  // pin encoding; deselect before link_up, then no-operation whenever nothing legal is ready
  always_comb begin
    pins_d.cke = cke_q;
    pins_d.cs_n = 1'b0;
    pins_d.ras_n = 1'b1;
    pins_d.cas_n = 1'b1;
    pins_d.we_n = 1'b1;
    pins_d.ba = req.bank;
    pins_d.a = req.addr;
    if (!link_up) begin
      pins_d.cs_n = 1'b1;
    end else if (issue) begin
      unique case (req.cmd)
        DXC_ACT: begin
          pins_d.ras_n = 1'b0;
        end
        DXC_RD: begin
          pins_d.cas_n = 1'b0;
          pins_d.a[AP_BIT] = req.ap;
        end
        DXC_WR: begin
          pins_d.cas_n = 1'b0;
          pins_d.we_n = 1'b0;
          pins_d.a[AP_BIT] = req.ap;
        end
        DXC_PRE: begin
          pins_d.ras_n = 1'b0;
          pins_d.we_n = 1'b0;
          pins_d.a[AP_BIT] = 1'b0;
        end
        DXC_REF: begin
          pins_d.ras_n = 1'b0;
          pins_d.cas_n = 1'b0;
        end
        DXC_LM: begin
          pins_d.ras_n = 1'b0;
          pins_d.cas_n = 1'b0;
          pins_d.we_n = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pins_q <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: '0, a: '0};
    end else if (tick) begin
      pins_q <= pins_d;
    end
  end

  // done and error pulse for one mclk; an activate, read, write or unused code that can never become
  // legal is refused, while refresh or load mode with a bank open is left to hang the requester
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= issue;
      err_q <= tick && req_valid && link_up && never && !done_q && !err_q;
    end
  end

endmodule // dxc_ctrl

// ---- dxc_ctrl_properties.sv ----
/*
  dxc_ctrl_properties: concurrent checks on the ports of the ddr2 command controller.
  Assumes it is bound to dxc_ctrl, sees only its ports and runs on mclk with rst.
*/
`timescale 1ns/1ps
module dxc_ctrl_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  input dxc_pkg::dxc_req_type req,
  input wire logic req_done,
  input wire logic req_err,
  // memory pins
  input wire logic ck,
  input wire logic ck_n,
  input dxc_pkg::dxc_pins_type pins
);
  import dxc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [2:0] op;
  assign op = {pins.ras_n, pins.cas_n, pins.we_n};
  a_ck_free_run: assert property (!$past(rst) |-> ck != $past(ck) && ck_n == !ck)
    else $error("memory clock pair not toggling");
  a_pins_at_fall: assert property ($changed(pins) |-> $fell(ck))
    else $error("pins changed away from a falling ck");
  a_done_drives_cmd: assert property (req_done |-> $fell(ck) && !pins.cs_n && op != 3'b111)
    else $error("done without a command on the pins");
  a_done_single: assert property (req_done |=> !req_done && !req_err)
    else $error("done pulse longer than one cycle");
  a_done_needs_req: assert property (req_done |-> !req_err && $past(req_valid))
    else $error("done without a held request");
  a_cke_before_cmd: assert property (req_done |-> pins.cke && $past(pins.cke, 2))
    else $error("command issued without cke high two cycles");
  a_bank_select: assert property (req_done && op != 3'b001 |-> pins.ba == req.bank)
    else $error("bank address differs from request");
  a_ap_select: assert property (req_done |-> (op[2:1] != 2'b10 || pins.a[AP_BIT] == req.ap)
    && (op != 3'b010 || !pins.a[AP_BIT]))
    else $error("auto precharge bit wrong");
  a_idle_nop: assert property ($changed(pins) && !req_done |-> pins.cs_n || op == 3'b111)
    else $error("unrequested command on the pins");
  a_lm_quiet: assert property (req_done && !pins.cs_n && op == 3'b000 |=> !req_done [*3])
    else $error("command too soon after load mode");
  c_rd_ap: cover property (req_done && op == 3'b101 && pins.a[AP_BIT]);
  c_wr: cover property (req_done && op == 3'b100);
  c_lm: cover property (req_done && op == 3'b000);
  c_err: cover property (req_err);
endmodule // dxc_ctrl_properties

bind dxc_ctrl dxc_ctrl_properties chk (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
  .req_done(req_done), .req_err(req_err), .ck(ck), .ck_n(ck_n), .pins(pins));

// ---- dxc_ctrl_test.sv ----
/*
  dxc_ctrl_test: self-checking bench for dxc_ctrl with a behavioural memory on its pins.
  Assumes the controller makes ck itself; requests are held until done or err.
*/
`timescale 1ns/1ps
module dxc_ctrl_test;
  import dxc_pkg::*;
  logic mclk = 0, rst = 1, req_valid = 0, req_done, req_err, ck, ck_n;
  dxc_req_type req = '0;
  dxc_pins_type pins;
  int errors = 0, n_tests = 0, bad_cnt, i;
  logic [31:0] seed = 32'hd22935b4, r;
  logic [NBANK-1:0] open_b = '0;
  always #2 mclk = ~mclk;
  dxc_ctrl uut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req), .req_done(req_done),
    .req_err(req_err), .ck(ck), .ck_n(ck_n), .pins(pins));
  dxc_mem_model mem (.ck(ck), .pins(pins), .bad(bad_cnt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [20:0] exp_pins(input dxc_req_type q);
    logic [3:0] c;
    logic [13:0] a;
    a = q.addr;
    case (q.cmd)
      DXC_ACT: c = 4'h3;
      DXC_RD: c = 4'h5;
      DXC_WR: c = 4'h4;
      DXC_PRE: c = 4'h2;
      DXC_REF: c = 4'h1;
      default: c = 4'h0;
    endcase
    if (q.cmd inside {DXC_RD, DXC_WR}) a[AP_BIT] = q.ap;
    if (q.cmd == DXC_PRE) a[AP_BIT] = 1'b0;
    return {c, q.bank, a};
  endfunction
  task automatic check(input logic [20:0] got, input logic [20:0] want);
    n_tests++;
    if (got !== want) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // never-legal requests are predicted from a bench-side view of open rows
  task automatic op(input dxc_cmd_type c, input logic ap, input logic [2:0] b, input logic [13:0] ad);
    logic e;
    logic [20:0] x, g;
    int n;
    e = (c == DXC_ACT) ? open_b[b] : (c inside {DXC_RD, DXC_WR}) ? !open_b[b] : 1'b0;
    @(posedge mclk);
    req_valid <= 1;
    req <= '{c, ap, b, ad};
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (req_done !== 1'b1 && req_err !== 1'b1 && n < 400);
    check(21'(req_done | req_err), 21'h1);
    check(21'(req_err), 21'(e));
    if (req_done === 1'b1) begin
      x = exp_pins(req);
      g = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.ba, pins.a};
      check(g[20:17], x[20:17]);
      if (c != DXC_REF) check(g[16:0], x[16:0]);
      if (c == DXC_ACT) open_b[b] = 1;
      if (c == DXC_PRE || (ap && c inside {DXC_RD, DXC_WR})) open_b[b] = 0;
    end
    @(posedge mclk);
    req_valid <= 0;
  endtask
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    op(DXC_RD, 0, 0, 14'h0005);
    op(DXC_WR, 1, 6, 14'h0011);
    for (i = 0; i < NBANK; i++) op(DXC_ACT, 0, 3'(i), 14'(rnd() >> 18));
    op(DXC_ACT, 0, 3, 14'h0123);
    op(DXC_RD, 0, 0, 14'h0400);
    op(DXC_WR, 0, 1, 14'h0008);
    op(DXC_RD, 0, 2, 14'h0010);
    op(DXC_RD, 1, 0, 14'h0020);
    op(DXC_WR, 1, 1, 14'h0030);
    op(DXC_RD, 0, 0, 14'h0040);
    op(DXC_ACT, 0, 0, 14'h1abc);
    op(DXC_ACT, 0, 1, 14'h0abc);
    for (i = 0; i < NBANK; i++) op(DXC_PRE, 0, 3'(i), 14'h3fff);
    op(DXC_REF, 0, 0, 14'h0000);
    op(DXC_LM, 0, 2, 14'h0042);
    op(DXC_ACT, 0, 5, 14'h0777);
    for (i = 0; i < 300; i++) begin
      r = rnd();
      op(dxc_cmd_type'({1'b0, r[1:0]}), r[2], r[5:3], r[19:6]);
    end
    repeat (40) @(posedge mclk);
    check(bad_cnt[20:0], 21'h0);
    final_report();
  end
endmodule // dxc_ctrl_test

// ---- dxc_mem_model.sv ----
/*
  dxc_mem_model: behavioural multi-bank memory that decodes commands and counts illegal ones.
  Assumes pins are stable at rising ck; one count unit is one memory clock cycle.
*/
`timescale 1ns/1ps
module dxc_mem_model (
  // memory pins
  input wire logic ck,
  input dxc_pkg::dxc_pins_type pins,
  // illegal commands seen
  output int bad
);
  import dxc_pkg::*;
  localparam int WTR = ((T_WTR_PS + TCK_PS - 1) / TCK_PS > 2) ? (T_WTR_PS + TCK_PS - 1) / TCK_PS : 2;
  int t, e, rd_t, wr_t, quiet_t;
  int free_t[NBANK], col_t[NBANK], end_t[NBANK];
  logic open[NBANK];
  logic cke_q, ok, rd;
  logic [BAW-1:0] b;
  initial begin
    bad = 0; t = 0; rd_t = -99; wr_t = -99; quiet_t = 0; cke_q = 0;
    foreach (open[i]) begin
      open[i] = 0; free_t[i] = 0; col_t[i] = 0; end_t[i] = 0;
    end
  end
  // per-bank bookkeeping checks each command against its target bank; refresh and load mode against all banks
  always @(posedge ck) begin
    b = pins.ba;
    if (cke_q && pins.cke && !pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} != 3'b111) begin
      ok = t >= quiet_t;
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'b011: begin
          ok &= !open[b] && t >= free_t[b];
          open[b] = 1; col_t[b] = t + RCD_CYC - AL;
        end
        3'b101, 3'b100: begin
          rd = pins.we_n;
          ok &= open[b] && t >= col_t[b];
          if (rd) ok &= t - rd_t >= BL / 2 && t - wr_t >= CL - 1 + BL / 2 + WTR;
          else ok &= t - wr_t >= BL / 2 && t - rd_t >= BL / 2 + 2;
          if (rd) rd_t = t;
          else wr_t = t;
          e = t + (rd ? AL + BL / 2 : WL + BL / 2 + WR_CYC);
          end_t[b] = e;
          if (pins.a[AP_BIT]) begin
            open[b] = 0; free_t[b] = e + RP_CYC;
          end
        end
        3'b010: begin
          ok &= t >= end_t[b];
          if (open[b]) free_t[b] = t + RP_CYC;
          open[b] = 0;
        end
        3'b001, 3'b000: begin
          foreach (open[i]) ok &= !open[i] && t >= free_t[i];
          quiet_t = t + (pins.we_n ? RFC_CYC : T_MRD_CK);
        end
        default: ok = 0;
      endcase
      if (!ok) bad++;
    end
    cke_q = pins.cke;
    t++;
  end
endmodule // dxc_mem_model

// ---- dxc_pkg.sv ----
/*
  dxc_pkg: shared constants, types and helpers for the ddr2 command controller.
  Assumes mclk at 250 MHz and a memory clock made by halving mclk.
*/
package dxc_pkg;

  // clocking: memory clock is mclk divided by two
  localparam int MCLK_PS = 4000;
  localparam int TCK_PS = 2 * MCLK_PS;

  // memory timing in its own unit, then in memory clock cycles (least times round up)
  localparam int T_RCD_PS = 15000;
  localparam int T_RP_PS = 15000;
  localparam int T_WR_PS = 15000;
  localparam int T_WTR_PS = 7500;
  localparam int T_RFC_PS = 127500;
  localparam int T_MRD_CK = 2;
  localparam int RCD_CYC = (T_RCD_PS + TCK_PS - 1) / TCK_PS;
  localparam int RP_CYC = (T_RP_PS + TCK_PS - 1) / TCK_PS;
  localparam int WR_CYC = (T_WR_PS + TCK_PS - 1) / TCK_PS;
  localparam int WTR_RAW = (T_WTR_PS + TCK_PS - 1) / TCK_PS;
  localparam int WTR_CYC = (WTR_RAW > 2) ? WTR_RAW : 2;
  localparam int RFC_CYC = (T_RFC_PS + TCK_PS - 1) / TCK_PS;

  // programmed latencies and burst length
  localparam int CL = 4;
  localparam int AL = 0;
  localparam int BL = 4;
  localparam int WL = AL + CL - 1;

  // bank-to-bank gaps after a column command, in memory clock cycles
  localparam int GAP_RD_RD = BL / 2;
  localparam int GAP_RD_WR = BL / 2 + 2;
  localparam int GAP_WR_WR = BL / 2;
  localparam int GAP_WR_RD = (CL - 1) + BL / 2 + WTR_CYC;

  // per-bank occupancy after a column command
  localparam int RD_ACCESS_CYC = AL + BL / 2;
  localparam int WR_ACCESS_CYC = WL + BL / 2 + WR_CYC;

  localparam int CW = 6;
  localparam int NBANK = 8;
  localparam int BAW = 3;
  localparam int AW = 14;
  localparam int AP_BIT = 10;
  localparam logic [CW-1:0] CNT_ZERO = 6'h00;

  typedef enum logic [2:0] {
    DXC_ACT, DXC_RD, DXC_WR, DXC_PRE, DXC_REF, DXC_LM
  } dxc_cmd_type;

  typedef enum logic [2:0] {
    DXC_IDLE, DXC_ACTIVATING, DXC_ACTIVE, DXC_READING,
    DXC_WRITING, DXC_RD_AP, DXC_WR_AP, DXC_PRECHARGING
  } dxc_bank_state_type;

  typedef struct packed {
    dxc_cmd_type cmd;
    logic ap;
    logic [BAW-1:0] bank;
    logic [AW-1:0] addr;
  } dxc_req_type;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BAW-1:0] ba;
    logic [AW-1:0] a;
  } dxc_pins_type;

  function automatic logic [CW-1:0] dxc_cyc(input int n);
    dxc_cyc = CW'((n > 0) ? n - 1 : 0);
  endfunction

  function automatic logic [CW-1:0] dxc_dec(input logic [CW-1:0] v);
    dxc_dec = (v == CNT_ZERO) ? CNT_ZERO : v - 6'h01;
  endfunction

  function automatic logic [CW-1:0] dxc_max(input logic [CW-1:0] x, input logic [CW-1:0] y);
    dxc_max = (x > y) ? x : y;
  endfunction

endpackage
